// >>> hdl/bldc_sync_pwm_timer.sv
// Three-channel BLDC timer: start-up compares, rotor capture, sync PWM, APB slave
`default_nettype none
module bldc_sync_pwm_timer
   import bldc_pwm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NPOS-1:0] rotor_pos,
   output logic [NPOS-1:0] drive_pos,
   output logic [NPOS-1:0] drive_neg,
   output logic irq
);
   typedef struct packed {
      logic [NCH-1:0][CNT_W-1:0] cnt;
      logic [NCH-1:0][REG_W-1:0] ctrl;
      logic [NCH-1:0][REG_W-1:0] ier;
      logic [NCH-1:0][REG_W-1:0] flag;
      logic [NCH-1:0][REG_W-1:0] io;
      logic [NCH-1:0][NGR-1:0][CNT_W-1:0] gr;
      logic [REG_W-1:0] mode;
      logic [REG_W-1:0] gate;
      logic [REG_W-1:0] outen;
      logic [CNT_W-1:0] duty_v;
      logic [CNT_W-1:0] duty_w;
      logic [NPOS-1:0] pwm_lvl;
      logic [NPOS-1:0] pos_prev;
      logic [NPOS-1:0] pos_cap;
      logic [NPOS-1:0] pins_pos;
      logic [NPOS-1:0] pins_neg;
      logic [31:0] prdata;
      logic pslverr;
      logic irq;
   } state_s;

   state_s s_r;
   state_s s_nxt;
   logic [NSEL-1:0] psc_tick;
   logic [NCH-1:0] ch_tick;
   logic [NCH-1:0] clr_ev;
   logic [NCH-1:0] cnt_wr;
   logic [NCH-1:0][NGR-1:0] match;
   logic [NPOS-1:0] cap_ev;
   logic [NPOS-1:0] rise;
   logic [NPOS-1:0] fall;
   logic [NPOS-1:0][CNT_W-1:0] duty;
   logic rsync;
   logic wr_acc;
   logic rd_setup;

   clk_prescaler #(
      .W(PSC_W),
      .N(NSEL)
   ) u_psc (
      .pclk(pclk),
      .presetn(presetn),
      .tick(psc_tick)
   );

   // Selects 7 map onto the slowest ratio so no code is undefined
   function automatic logic tick_pick(input logic [2:0] sel, input logic [NSEL-1:0] t);
      logic r;
      r = (sel >= 3'(NSEL)) ? t[NSEL-1] : t[sel];
      return r;
   endfunction

   // Word-aligned hits only; everything else answers with an error
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      logic r;
      r = 1'b0;
      if (a[1:0] == 2'h0) begin
         if (a[7:6] == GLOBAL_WIN) begin
            r = (a >= OFF_MODE) && (a <= OFF_DUTY_W);
         end else begin
            r = (a[5:0] <= OFF_GR_LAST);
         end
      end
      return r;
   endfunction

   // Capture edge test for one I/O select field
   function automatic logic edge_hit(input logic [1:0] f, input logic r, input logic fl);
      logic h;
      h = ((f == IO_RISE) && r) || ((f == IO_FALL) && fl) || ((f == IO_BOTH) && (r || fl));
      return h;
   endfunction

   // Six-step commutation from rotor state: {negative, positive}
   function automatic logic [5:0] commute(input logic [NPOS-1:0] h);
      logic [5:0] e;
      case (h)
         3'h5: e = 6'h11;
         3'h4: e = 6'h21;
         3'h6: e = 6'h22;
         3'h2: e = 6'h0a;
         3'h3: e = 6'h0c;
         3'h1: e = 6'h14;
         default: e = 6'h00;
      endcase
      return e;
   endfunction

   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign rsync = (s_r.mode[3:0] == MODE_RSYNC);
   assign rise = rotor_pos & ~s_r.pos_prev;
   assign fall = ~rotor_pos & s_r.pos_prev;
   assign duty[0] = s_r.gr[CH_PWM][GR_B];
   assign duty[1] = s_r.duty_v;
   assign duty[2] = s_r.duty_w;

   // Per-channel count enable, compare equality and clear event
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic clr_a;
      assign ch_tick[c] = tick_pick(s_r.ctrl[c][CTRL_PSC_LSB +: 3], psc_tick);
      for (genvar g = 0; g < NGR; g++) begin : g_gr
         assign match[c][g] = (s_r.cnt[c] == s_r.gr[c][g]);
      end
      // In sync PWM mode the period match always clears the PWM counter
      assign clr_a = s_r.ctrl[c][CTRL_CLR_A] || (c == CH_PWM && rsync);
      assign clr_ev[c] = ch_tick[c] && ((clr_a && match[c][GR_A]) ||
                         (s_r.ctrl[c][CTRL_CLR_D] && match[c][GR_D]));
      assign cnt_wr[c] = wr_acc && mapped(paddr) && (paddr[7:6] == 2'(c)) &&
                         (paddr[5:0] == OFF_CNT);
   end

   // Rotor inputs reach channel 0 registers A, B and C
   for (genvar p = 0; p < NPOS; p++) begin : g_cap
      assign cap_ev[p] = edge_hit(s_r.io[CH_START0][2*p +: 2], rise[p], fall[p]);
   end

   // Whole next-state: software writes, then hardware events, then outputs
   always_comb begin
      logic [1:0] ch;
      logic [5:0] off;
      logic [5:0] gd;
      logic [1:0] gi;
      logic [5:0] ener;
      logic [31:0] rd;
      s_nxt = s_r;
      ch = paddr[7:6];
      off = paddr[5:0];
      gd = 6'(off - OFF_GR);
      gi = gd[3:2];
      ener = 6'h00;
      rd = 32'h0000_0000;
      // Register writes take effect in the access phase only
      if (wr_acc && mapped(paddr)) begin
         if (ch == GLOBAL_WIN) begin
            case (paddr)
               OFF_MODE: s_nxt.mode = pwdata[7:0];
               OFF_GATE: s_nxt.gate = pwdata[7:0];
               OFF_OUTEN: s_nxt.outen = pwdata[7:0];
               OFF_DUTY_V: s_nxt.duty_v = pwdata[15:0];
               OFF_DUTY_W: s_nxt.duty_w = pwdata[15:0];
               default: ;
            endcase
         end else begin
            case (off)
               OFF_CTRL: s_nxt.ctrl[ch] = pwdata[7:0];
               OFF_IER: s_nxt.ier[ch] = pwdata[7:0];
               OFF_FLAG: s_nxt.flag[ch] = s_r.flag[ch] & ~pwdata[7:0];
               OFF_IO: s_nxt.io[ch] = pwdata[7:0];
               OFF_CNT: ;
               default: s_nxt.gr[ch][gi] = pwdata[15:0];
            endcase
         end
      end
      // Counting, compare flags and overflow; flag set beats a clear
      for (int c = 0; c < NCH; c++) begin
         if (ch_tick[c]) begin
            s_nxt.cnt[c] = clr_ev[c] ? RST_CNT : CNT_W'(s_r.cnt[c] + 1'b1);
            if (s_r.cnt[c] == CNT_MAX) begin
               s_nxt.flag[c][FLAG_OVF] = 1'b1;
            end
            for (int g = 0; g < NGR; g++) begin
               if (s_r.io[c][2*g +: 2] == IO_CMP && match[c][g]) begin
                  s_nxt.flag[c][g] = 1'b1;
               end
            end
         end
      end
      // Rotor edges: latch counter, flag, and remember rotor state
      for (int p = 0; p < NPOS; p++) begin
         if (cap_ev[p]) begin
            s_nxt.gr[CH_START0][p] = s_r.cnt[CH_START0];
            s_nxt.flag[CH_START0][p] = 1'b1;
            s_nxt.pos_cap = rotor_pos;
         end
      end
      s_nxt.pos_prev = rotor_pos;
      // Software counter write overrides the count step
      for (int c = 0; c < NCH; c++) begin
         if (cnt_wr[c]) begin
            s_nxt.cnt[c] = pwdata[15:0];
         end
      end
      // Phase waveforms share the period clear as common transition
      for (int p = 0; p < NPOS; p++) begin
         if (!rsync || clr_ev[CH_PWM]) begin
            s_nxt.pwm_lvl[p] = 1'b0;
         end else if (ch_tick[CH_PWM] && s_r.cnt[CH_PWM] == duty[p]) begin
            s_nxt.pwm_lvl[p] = 1'b1;
         end
      end
      // Energized phases come from software bits or captured rotor state
      if (s_r.gate[GATE_FB]) begin
         ener = commute(s_r.pos_cap);
      end else begin
         ener = s_r.gate[5:0];
      end
      // Registered pins avoid glitches on the base driver inputs
      for (int p = 0; p < NPOS; p++) begin
         s_nxt.pins_pos[p] = rsync && ener[GATE_POS_LSB + p] && s_r.outen[p];
         s_nxt.pins_neg[p] = rsync && ener[GATE_NEG_LSB + p] && s_r.pwm_lvl[p] &&
                             s_r.outen[OUTEN_NEG_LSB + p];
      end
      // Read data is captured in the setup phase so pready never waits
      if (rd_setup) begin
         s_nxt.pslverr = !mapped(paddr);
         if (mapped(paddr) && !pwrite) begin
            if (ch == GLOBAL_WIN) begin
               case (paddr)
                  OFF_MODE: rd = {24'h000000, s_r.mode};
                  OFF_GATE: rd = {24'h000000, s_r.gate};
                  OFF_OUTEN: rd = {24'h000000, s_r.outen};
                  OFF_DUTY_V: rd = {16'h0000, s_r.duty_v};
                  OFF_DUTY_W: rd = {16'h0000, s_r.duty_w};
                  default: rd = 32'h0000_0000;
               endcase
            end else begin
               case (off)
                  OFF_CTRL: rd = {24'h000000, s_r.ctrl[ch]};
                  OFF_IER: rd = {24'h000000, s_r.ier[ch]};
                  OFF_FLAG: rd = {24'h000000, s_r.flag[ch]};
                  OFF_IO: rd = {24'h000000, s_r.io[ch]};
                  OFF_CNT: rd = {16'h0000, s_r.cnt[ch]};
                  default: rd = {16'h0000, s_r.gr[ch][gi]};
               endcase
            end
         end
         s_nxt.prdata = rd;
      end
      // Level interrupt from next flags so it tracks them without lag
      s_nxt.irq = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         s_nxt.irq = s_nxt.irq || (|(s_nxt.flag[c] & s_nxt.ier[c]));
      end
   end

   // Single state register; general registers start at full scale
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.gr <= {(NCH*NGR){RST_GR}};
         s_r.mode <= RST_REG;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pready = 1'b1;
   assign prdata = s_r.prdata;
   assign pslverr = s_r.pslverr;
   assign drive_pos = s_r.pins_pos;
   assign drive_neg = s_r.pins_neg;
   assign irq = s_r.irq;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence d_match_s;
      ch_tick[CH_START0] && match[CH_START0][GR_D] &&
      s_r.io[CH_START0][7:6] == IO_CMP;
   endsequence

   sequence cap_a_s;
      cap_ev[0] ##1 1'b1;
   endsequence

   // Interrupt level and start-up compare match
   irq_level_a: assert property (irq == |((s_r.flag & s_r.ier)))
      else $error("irq does not follow enabled flags");
   startup_flag_a: assert property (d_match_s |=> s_r.flag[CH_START0][GR_D])
      else $error("compare D match did not set its flag");
   // A mask write in the match cycle may legally keep the interrupt low
   startup_irq_a: assert property ((d_match_s and s_r.ier[CH_START0][GR_D] && !wr_acc) |=> irq)
      else $error("enabled compare flag gave no interrupt");

   // Rotor capture path
   capture_copy_a: assert property (cap_a_s |->
      s_r.gr[CH_START0][GR_A] == $past(s_r.cnt[CH_START0]))
      else $error("capture did not copy the counter");
   capture_flag_a: assert property (cap_ev[1] |=> s_r.flag[CH_START0][GR_B])
      else $error("rotor edge flag not set");
   capture_c_a: assert property (cap_ev[GR_C] |=> s_r.flag[CH_START0][GR_C])
      else $error("rotor C edge flag not set");
   // Falling-only selection ignores a rising rotor edge
   fall_only_a: assert property (s_r.io[CH_START0][2*GR_C +: 2] == IO_FALL &&
      rise[GR_C] |-> !cap_ev[GR_C])
      else $error("falling-only capture fired on a rising edge");

   // Counter stepping, loading and clearing
   period_clear_a: assert property (rsync && ch_tick[CH_PWM] && match[CH_PWM][GR_A] &&
      !cnt_wr[CH_PWM] |=> s_r.cnt[CH_PWM] == RST_CNT)
      else $error("PWM counter not cleared at period");
   count_step_a: assert property (ch_tick[CH_START1] && !clr_ev[CH_START1] &&
      !cnt_wr[CH_START1] |=> s_r.cnt[CH_START1] ==
      CNT_W'($past(s_r.cnt[CH_START1]) + 1'b1))
      else $error("counter did not step on its tick");
   hold_count_a: assert property (!ch_tick[CH_START1] && !cnt_wr[CH_START1] |=>
      $stable(s_r.cnt[CH_START1]))
      else $error("counter moved without its tick");
   // Software counter write wins over the count step
   count_write_a: assert property (cnt_wr[CH_START1] |=>
      s_r.cnt[CH_START1] == $past(pwdata[15:0]))
      else $error("software counter write lost");
   // Write-one clear drops a flag when no match sets it again
   flag_clear_a: assert property (wr_acc && paddr[7:6] == 2'(CH_START1) &&
      paddr[5:0] == OFF_FLAG && pwdata[GR_A] && !match[CH_START1][GR_A] |=>
      !s_r.flag[CH_START1][GR_A])
      else $error("flag not cleared by a one");

   // Pin gating and waveform shape
   outen_gate_a: assert property (!s_r.outen[OUTEN_NEG_LSB] |=> !drive_neg[0])
      else $error("disabled pin driven");
   neg_chop_a: assert property (drive_neg[0] |-> $past(s_r.pwm_lvl[0]))
      else $error("negative phase high outside PWM on time");
   duty_rise_a: assert property (rsync && ch_tick[CH_PWM] &&
      s_r.cnt[CH_PWM] == duty[1] && !clr_ev[CH_PWM] |=> s_r.pwm_lvl[1])
      else $error("phase did not rise at duty match");
   common_fall_a: assert property (rsync && clr_ev[CH_PWM] |=> s_r.pwm_lvl == 3'h0)
      else $error("phases do not share period transition");
   mode_off_a: assert property (!rsync |=> (drive_pos == 3'h0 && drive_neg == 3'h0))
      else $error("pins driven outside sync PWM mode");
   // Software-selected high side stays at a static level
   static_high_a: assert property (rsync && s_r.outen[0] &&
      s_r.gate[GATE_POS_LSB] && !s_r.gate[GATE_FB] |=> drive_pos[0])
      else $error("selected positive phase not held high");
   // Only the positive half of the table lands on the high-side pins
   auto_comm_a: assert property (rsync && s_r.gate[GATE_FB] &&
      s_r.outen[2:0] == 3'h7 |=> drive_pos == 3'($past(commute(s_r.pos_cap))))
      else $error("positive phases ignore captured rotor state");
endmodule
`default_nettype wire

// >>> inc/bldc_pwm_pkg.sv
// Constants, offsets and field layout shared by the BLDC PWM timer
// What this block does
// - Prescaler gives divide-by-2 up to divide-by-8192 ticks
// - Each channel has a 16-bit software-accessible counter
// - Control register picks clock and counter clear source
// - Enable register gates each status flag interrupt
// - Start-up compare D/A gives commutation interval interrupt
// - I/O select sets compare or capture and edge
// - Channel 0 captures rotor edges, raising interrupts
// - Channel 2 makes three-phase PWM, common transition
// - PWM counter clears on period match, selected clock
// - Gate register picks driven phases and feedback source
// - Period register plus three phase duty registers
// - Mode register selects reset-synchronized PWM mode
// - Output master enable gates every output pin
// - Positive phases static, negative phases chopped
// - Captured rotor state switches energized phases automatically
// - Capture edge copies counter into capture register
// - Compare equal sets flag; interrupt only when enabled
`default_nettype none
package bldc_pwm_pkg;
   localparam int NCH = 3;
   localparam int CH_START0 = 0;
   localparam int CH_START1 = 1;
   localparam int CH_PWM = 2;
   localparam int NGR = 4;
   localparam int GR_A = 0;
   localparam int GR_B = 1;
   localparam int GR_C = 2;
   localparam int GR_D = 3;
   localparam int NPOS = 3;
   localparam int CNT_W = 16;
   localparam int REG_W = 8;
   localparam int PSC_W = 13;
   localparam int NSEL = 7;
   localparam int ADDR_W = 8;
   // Per-channel word offsets inside a 0x40 channel window
   localparam logic [5:0] OFF_CTRL = 6'h00;
   localparam logic [5:0] OFF_IER = 6'h04;
   localparam logic [5:0] OFF_FLAG = 6'h08;
   localparam logic [5:0] OFF_IO = 6'h0c;
   localparam logic [5:0] OFF_CNT = 6'h10;
   localparam logic [5:0] OFF_GR = 6'h14;
   localparam logic [5:0] OFF_GR_LAST = 6'h20;
   localparam logic [1:0] GLOBAL_WIN = 2'h3;
   // Global registers
   localparam logic [7:0] OFF_MODE = 8'hc0;
   localparam logic [7:0] OFF_GATE = 8'hc4;
   localparam logic [7:0] OFF_OUTEN = 8'hc8;
   localparam logic [7:0] OFF_DUTY_V = 8'hcc;
   localparam logic [7:0] OFF_DUTY_W = 8'hd0;
   // Control register fields
   localparam int CTRL_PSC_LSB = 0;
   localparam int CTRL_CLR_A = 3;
   localparam int CTRL_CLR_D = 4;
   localparam int FLAG_OVF = 4;
   // I/O select: two bits per general register
   localparam logic [1:0] IO_CMP = 2'h0;
   localparam logic [1:0] IO_RISE = 2'h1;
   localparam logic [1:0] IO_FALL = 2'h2;
   localparam logic [1:0] IO_BOTH = 2'h3;
   localparam logic [3:0] MODE_RSYNC = 4'h8;
   localparam int GATE_POS_LSB = 0;
   localparam int GATE_NEG_LSB = 3;
   localparam int GATE_FB = 6;
   localparam int OUTEN_NEG_LSB = 3;
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [15:0] RST_GR = 16'hffff;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [15:0] CNT_MAX = 16'hffff;
endpackage
`default_nettype wire

// >>> hdl/clk_prescaler.sv
// Free-running divider producing one-cycle count enables
`default_nettype none
module clk_prescaler
   import bldc_pwm_pkg::*;
#(
   parameter int W = PSC_W,
   parameter int N = NSEL
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic [N-1:0] tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } psc_s;
   psc_s s_r;
   psc_s s_nxt;

   // Counter simply wraps; every ratio is a power of two of it
   always_comb begin
      s_nxt = s_r;
      s_nxt.cnt = W'(s_r.cnt + 1'b1);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Tick k fires once per 2**(2k+1) cycles: 2, 8, 32 ... 8192
   for (genvar k = 0; k < N; k++) begin : g_tick
      assign tick[k] = &s_r.cnt[2*k:0];
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   div_two_a: assert property (tick[0] |=> !tick[0] ##1 tick[0])
      else $error("divide-by-2 tick not alternating");
   div_top_a: assert property (tick[N-1] |=> !tick[N-1] [*8])
      else $error("slowest tick repeats too soon");
endmodule
`default_nettype wire

// >>> test/rotor_motor_model.sv
// Motor-side model: rotor position sensors and base-driver load
`default_nettype none
module rotor_motor_model
   import bldc_pwm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [NPOS-1:0] hall_cmd,
   input wire logic [NPOS-1:0] drive_neg,
   output logic [NPOS-1:0] rotor_pos,
   output logic [15:0] chop_count
);
   logic [NPOS-1:0] neg_q;
   // Sensors move only on a clock edge so the sampler never sees a glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rotor_pos <= '0;
         neg_q <= '0;
         chop_count <= 16'h0000;
      end else begin
         rotor_pos <= hall_cmd;
         neg_q <= drive_neg;
         // Count chopping pulses seen by the low-side drivers
         if (|(drive_neg & ~neg_q)) begin
            chop_count <= chop_count + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// >>> test/bldc_sync_pwm_timer_tb.sv
// Self-checking bench for the BLDC sync PWM timer
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
$display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module bldc_sync_pwm_timer_tb
   import bldc_pwm_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [NPOS-1:0] rotor_pos;
   logic [NPOS-1:0] drive_pos;
   logic [NPOS-1:0] drive_neg;
   logic irq;
   logic [NPOS-1:0] hall_cmd = '0;
   logic [15:0] chop_count;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] d;
   logic e;

   always #5 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   bldc_sync_pwm_timer bldc_sync_pwm_timer_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rotor_pos(rotor_pos), .drive_pos(drive_pos),
      .drive_neg(drive_neg), .irq(irq));
   rotor_motor_model rotor_motor_model_inst (.pclk(pclk), .presetn(presetn),
      .hall_cmd(hall_cmd), .drive_neg(drive_neg), .rotor_pos(rotor_pos),
      .chop_count(chop_count));

   // Verdict and end of run; also reached when a wait runs out
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // One APB transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         $display("BAD pready wait expected 1 seen %0h", pready);
         test_done();
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(a, 1'b1, v);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(a, 1'b0, 32'h0);
   endtask

   // Bounded wait for irq, sampled at the falling edge where it is settled
   task automatic wait_irq(input logic v, input int bound);
      int n;
      n = 0;
      while (irq !== v && n < bound) begin
         @(negedge pclk);
         n++;
      end
      if (irq !== v) begin
         err_count++;
         $display("BAD irq wait expected %0h seen %0h", v, irq);
         test_done();
      end
   endtask

   // Count high samples of every drive pin over n cycles
   task automatic sample(input int n, output int pc[3], output int nc[3]);
      pc = '{0, 0, 0};
      nc = '{0, 0, 0};
      for (int i = 0; i < n; i++) begin
         @(negedge pclk);
         for (int b = 0; b < 3; b++) begin
            pc[b] += int'(drive_pos[b] === 1'b1);
            nc[b] += int'(drive_neg[b] === 1'b1);
         end
      end
   endtask

   task automatic t_reset();
      rd(8'h94);
      `CHK("period reset", 32'h0000ffff, d)
      rd(8'h80);
      `CHK("ctrl reset", 32'h0, d)
      `CHK("irq reset", 1'b0, irq)
      `CHK("drive idle", 6'h00, {drive_pos, drive_neg})
      rd(8'hfc);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped data", 32'h0, d)
      $display("test reset done");
   endtask

   // Compare match with clear: masked flag, then timed interrupts
   task automatic t_cmp(input logic [7:0] base, input logic [7:0] ga, input logic [4:0] fm,
                        input logic [7:0] ctl, input int iv);
      int n;
      int tr[2];
      wr(ga, 32'h10);
      wr(base, {24'h0, ctl});
      wr(base + 8'h10, 32'h0);
      wr(base + 8'h08, 32'h1f);
      n = 0;
      do begin
         rd(base + 8'h08);
         n++;
      end while (d[4:0] !== fm && n < 80);
      `CHK("match flag", fm, d[4:0])
      `CHK("masked irq", 1'b0, irq)
      wr(base + 8'h04, {27'h0, fm});
      wait_irq(1'b1, 10);
      for (int k = 0; k < 2; k++) begin
         wr(base + 8'h08, {27'h0, fm});
         wait_irq(1'b0, 10);
         wait_irq(1'b1, 200);
         tr[k] = cyc;
      end
      `CHK("match interval", iv, tr[1] - tr[0])
      wr(base + 8'h04, 32'h0);
      wr(base, 32'h0);
      wait_irq(1'b0, 10);
      $display("test compare done");
   endtask

   // Rotor edges captured on channel 0 A (both) and B (rising only)
   task automatic t_capture();
      logic [2:0] hs [4] = '{3'b001, 3'b000, 3'b010, 3'b000};
      logic [2:0] fx [4] = '{3'h1, 3'h1, 3'h2, 3'h0};
      logic [15:0] c0;
      wr(8'h0c, 32'h07);
      wr(8'h04, 32'h03);
      wr(8'h08, 32'h1f);
      for (int k = 0; k < 4; k++) begin
         rd(8'h10);
         c0 = d[15:0];
         @(posedge pclk);
         hall_cmd <= hs[k];
         if (fx[k] != 3'h0) begin
            wait_irq(1'b1, 20);
         end else begin
            repeat (20) @(posedge pclk);
         end
         rd(8'h08);
         `CHK("capture flag", fx[k], d[2:0])
         `CHK("capture irq", |fx[k], irq)
         rd(8'h14);
         if (k == 0) `CHK("capture value", 1'b1, (d[15:0] - c0) < 16'd8)
         wr(8'h08, 32'h1f);
         wait_irq(1'b0, 10);
      end
      wr(8'h0c, 32'h0);
      wr(8'h04, 32'h0);
      $display("test capture done");
   endtask

   // Reset-synchronized PWM: duty per phase, static high side, master enable
   task automatic t_pwm();
      int pc[3];
      int nc[3];
      logic [15:0] c0;
      wr(8'hc0, 32'h08);
      wr(8'h80, 32'h08);
      wr(8'h90, 32'h0);
      wr(8'h94, 32'd20);
      wr(8'h98, 32'd5);
      wr(8'hcc, 32'd10);
      wr(8'hd0, 32'd15);
      wr(8'hc8, 32'h3f);
      for (int p = 0; p < 3; p++) begin
         wr(8'hc4, 32'(1 << ((p + 1) % 3)) | 32'(8 << p));
         repeat (4) @(negedge pclk);
         c0 = chop_count;
         sample(210, pc, nc);
         `CHK("neg chop high", 150 - 50 * p, nc[p])
         `CHK("pos static", 210, pc[(p + 1) % 3])
         `CHK("unselected neg", 0, nc[(p + 1) % 3] + nc[(p + 2) % 3])
         `CHK("chop pulses", 16'd5, chop_count - c0)
      end
      wr(8'hc8, 32'h07);
      repeat (4) @(negedge pclk);
      sample(42, pc, nc);
      `CHK("neg disabled", 0, nc[0] + nc[1] + nc[2])
      `CHK("pos enabled", 42, pc[0])
      wr(8'hc8, 32'h00);
      repeat (4) @(negedge pclk);
      sample(42, pc, nc);
      `CHK("pos disabled", 0, pc[0] + pc[1] + pc[2])
      $display("test pwm done");
   endtask

   // Energized phases follow the rotor state through the table
   task automatic t_commute();
      logic [2:0] st [7] = '{3'd5, 3'd4, 3'd6, 3'd2, 3'd3, 3'd1, 3'd0};
      logic [2:0] ep [7] = '{3'b001, 3'b001, 3'b010, 3'b010, 3'b100, 3'b100, 3'b000};
      logic [2:0] en [7] = '{3'b010, 3'b100, 3'b100, 3'b001, 3'b001, 3'b010, 3'b000};
      int pc[3];
      int nc[3];
      wr(8'hc8, 32'h3f);
      wr(8'hc4, 32'h40);
      // Rotor state is latched only on a capture edge: A, B both, C falling
      wr(8'h0c, 32'h2f);
      wr(8'h08, 32'h1f);
      for (int k = 0; k < 7; k++) begin
         @(posedge pclk);
         hall_cmd <= st[k];
         repeat (6) @(negedge pclk);
         sample(42, pc, nc);
         for (int b = 0; b < 3; b++) begin
            `CHK("commutate pos", ep[k][b] ? 42 : 0, pc[b])
            `CHK("commutate neg", en[k][b] ? 40 - 10 * (b + 1) : 0, nc[b])
         end
         if (k == 0) begin
            rd(8'h08);
            `CHK("rise ignored", 1'b0, d[GR_C])
         end
      end
      rd(8'h08);
      `CHK("fall captured", 1'b1, d[GR_C])
      $display("test commutation done");
   endtask

   // Reset for three cycles, then the scenarios in turn
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      // Interval is (compare value + 1) ticks of the selected ratio
      t_cmp(8'h00, 8'h20, 5'h08, 8'h10, 34);
      t_cmp(8'h40, 8'h54, 5'h01, 8'h09, 136);
      t_capture();
      t_pwm();
      t_commute();
      test_done();
   end
endmodule
`default_nettype wire
